// ==== bst_pkg.sv ====
// boundary-scan test access port: shared constants, types and functions
// assumes a 7-bit instruction register and one 51-cell boundary chain
package bst_pkg;

    // ***************************************************
    // instruction register
    // ***************************************************
    localparam int IR_W = 7;
    localparam logic [IR_W-1:0] OP_EXTEST = 7'h00;
    localparam logic [IR_W-1:0] OP_SAMPLE = 7'h01;
    localparam logic [IR_W-1:0] OP_CLAMP = 7'h02;
    localparam logic [IR_W-1:0] OP_HIGHZ = 7'h03;
    localparam logic [IR_W-1:0] OP_IDCODE = 7'h04;
    localparam logic [IR_W-1:0] OP_BYPASS = 7'h7F;
    localparam logic [IR_W-1:0] IR_CAPTURE = 7'h01;

    // ***************************************************
    // data registers and chain cell positions (cell 0 is nearest tdo)
    // ***************************************************
    localparam int ID_W = 32;
    localparam int ID_VER_LSB = 28;
    localparam int ID_PART_LSB = 12;
    localparam int ID_MFR_LSB = 1;
    localparam int BSR_LEN = 51;
    localparam int C_HWRST = 0;
    localparam int C_CLK125 = 1;
    localparam int C_CFG6 = 2;
    localparam int C_CFG5 = 3;
    localparam int C_COMA = 4;
    localparam int C_TXD7 = 5;
    localparam int C_TXEN = 13;
    localparam int C_GTX = 14;
    localparam int C_TXER = 15;
    localparam int C_TXCLK = 16;
    localparam int C_CRS = 17;
    localparam int C_COLIN = 18;
    localparam int C_COLOUT = 19;
    localparam int C_COLOE = 20;
    localparam int C_RXER = 21;
    localparam int C_RXCLK = 22;
    localparam int C_RXDV = 23;
    localparam int C_RXD0 = 24;
    localparam int C_GRPOE = 32;
    localparam int C_MDC = 33;
    localparam int C_MDIOIN = 34;
    localparam int C_MDIOOUT = 35;
    localparam int C_MDIOOE = 36;
    localparam int C_IRQ = 37;
    localparam int C_IRQOE = 38;
    localparam int C_LED0 = 39;
    localparam int C_LEDOE = 45;
    localparam int C_CFG0 = 46;

    // ***************************************************
    // types
    // ***************************************************
    typedef enum logic [3:0] {
        T_RESET, T_IDLE, T_SEL_DR, T_CAP_DR, T_SHIFT_DR, T_EXIT1_DR, T_PAUSE_DR,
        T_EXIT2_DR, T_UPD_DR, T_SEL_IR, T_CAP_IR, T_SHIFT_IR, T_EXIT1_IR,
        T_PAUSE_IR, T_EXIT2_IR, T_UPD_IR
    } bst_tap_t;

    typedef enum logic [2:0] {
        I_EXTEST, I_SAMPLE, I_CLAMP, I_HIGHZ, I_BYPASS, I_IDCODE
    } bst_instr_t;

    typedef struct packed {
        logic hw_reset;
        logic [6:0] cfg;
        logic coma;
        logic [7:0] txd;
        logic tx_en;
        logic gtx_clk;
        logic tx_er;
        logic col_in;
        logic mdc;
        logic mdio_in;
    } bst_pin_in_t;

    typedef struct packed {
        logic clk125;
        logic clk125_oe;
        logic tx_clk;
        logic crs;
        logic col;
        logic col_oe;
        logic rx_er;
        logic rx_clk;
        logic rx_dv;
        logic [7:0] rxd;
        logic mac_oe;
        logic mdio_out;
        logic mdio_oe;
        logic irq;
        logic irq_oe;
        logic [5:0] led;
        logic led_oe;
    } bst_pin_out_t;

    // unknown opcodes fall back to bypass
    function automatic bst_instr_t bst_decode(input logic [IR_W-1:0] op);
        unique case (op)
            OP_EXTEST: return I_EXTEST;
            OP_SAMPLE: return I_SAMPLE;
            OP_CLAMP: return I_CLAMP;
            OP_HIGHZ: return I_HIGHZ;
            OP_IDCODE: return I_IDCODE;
            default: return I_BYPASS;
        endcase
    endfunction

endpackage

// ==== bst_tap.sv ====
// boundary-scan test access port with identification, bypass and boundary chain
// assumes core_out comes from logic on clock; pin_in and tms/tdi come from pins
// Operation
// - six instructions: extest, sample/preload, clamp, high-z, bypass, idcode
// - opcodes 00,01,02,03,7F,04 on a seven-bit instruction register
// - test logic reset loads the idcode instruction
// - port is tms, tck, tdi, tdo and active-low test reset
// - tms/tdi sampled on rising tck, tdo changes on falling tck
// - bypass gives one flip-flop between tdi and tdo
// - sample/preload leaves functional pins undisturbed
// - sample captures every pin or core value except clk125_oe in capture-dr
// - preload moves shifted pattern into update stage, not onto pins
// - captured data shifts out while new data shifts in
// - extest drives latched boundary values onto outputs on the fourth functional clock edge after the update
// - clamp holds outputs from update stage, bypass is serial path
// - high-z releases every system output enable
// - id register holds version, part, maker and a one in bit 0
// - one chain from hardware reset cell to low strap cells
// - group enable cell plus collision, mdio, irq, indicator enable cells
// - management data pin has input, output and enable cells
`timescale 1ns/10ps
module bst_tap #(
    parameter logic [3:0] ID_VERSION = 4'h1,
    // arbitrary identification values
    parameter logic [15:0] ID_PART = 16'h0001,
    parameter logic [10:0] ID_MAKER = 11'h001
) (
    // functional clock domain
    input wire logic clock,
    input wire logic rst_n,
    input wire bst_pkg::bst_pin_out_t core_out,
    input wire bst_pkg::bst_pin_in_t pin_in,
    output bst_pkg::bst_pin_out_t pin_out,
    // test port
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic test_reset_low,
    output logic tdo,
    output logic tdo_oe
);
    import bst_pkg::*;

    // ***************************************************
    // state
    // ***************************************************
    typedef struct packed {
        bst_tap_t tap;
        logic [IR_W-1:0] ir_sh;
        logic [IR_W-1:0] ir;
        logic byp;
        logic [ID_W-1:0] id_sh;
        logic [BSR_LEN-1:0] bsr_sh;
        logic [BSR_LEN-1:0] upd;
        logic tog;
        bst_pin_in_t pin_s1;
        bst_pin_in_t pin_s2;
        bst_pin_out_t core_s1;
        bst_pin_out_t core_s2;
    } bst_tck_t;

    typedef struct packed {
        logic tdo;
        logic tdo_oe;
    } bst_neg_t;

    typedef struct packed {
        logic tog_s1;
        logic tog_s2;
        logic tog_s3;
        logic trst_s1;
        logic trst_s2;
        bst_instr_t instr;
        logic [BSR_LEN-1:0] upd;
        bst_pin_out_t pin_out;
    } bst_clk_t;

    localparam logic [ID_W-1:0] ID_VALUE = (ID_W'(ID_VERSION) << ID_VER_LSB)
        | (ID_W'(ID_PART) << ID_PART_LSB) | (ID_W'(ID_MAKER) << ID_MFR_LSB) | ID_W'(1);

    bst_tck_t t_ff, nxt_t;
    bst_neg_t n_ff, nxt_n;
    bst_clk_t c_ff, nxt_c;
    bst_instr_t cur_instr;
    logic bsr_sel;
    logic [BSR_LEN-1:0] cap_vec;

    // ***************************************************
    // helpers
    // ***************************************************
    function automatic bst_tap_t tap_next(input bst_tap_t s, input logic m);
        unique case (s)
            T_RESET: return m ? T_RESET : T_IDLE;
            T_IDLE: return m ? T_SEL_DR : T_IDLE;
            T_SEL_DR: return m ? T_SEL_IR : T_CAP_DR;
            T_CAP_DR: return m ? T_EXIT1_DR : T_SHIFT_DR;
            T_SHIFT_DR: return m ? T_EXIT1_DR : T_SHIFT_DR;
            T_EXIT1_DR: return m ? T_UPD_DR : T_PAUSE_DR;
            T_PAUSE_DR: return m ? T_EXIT2_DR : T_PAUSE_DR;
            T_EXIT2_DR: return m ? T_UPD_DR : T_SHIFT_DR;
            T_UPD_DR: return m ? T_SEL_DR : T_IDLE;
            T_SEL_IR: return m ? T_RESET : T_CAP_IR;
            T_CAP_IR: return m ? T_EXIT1_IR : T_SHIFT_IR;
            T_SHIFT_IR: return m ? T_EXIT1_IR : T_SHIFT_IR;
            T_EXIT1_IR: return m ? T_UPD_IR : T_PAUSE_IR;
            T_PAUSE_IR: return m ? T_EXIT2_IR : T_PAUSE_IR;
            T_EXIT2_IR: return m ? T_UPD_IR : T_SHIFT_IR;
            T_UPD_IR: return m ? T_SEL_DR : T_IDLE;
        endcase
    endfunction

    // what the pins carry for a given instruction
    function automatic bst_pin_out_t drive(input bst_instr_t in,
                                           input logic [BSR_LEN-1:0] u,
                                           input bst_pin_out_t core);
        bst_pin_out_t p;
        p = core;
        if (in == I_EXTEST || in == I_CLAMP) begin
            p.clk125 = u[C_CLK125];
            p.clk125_oe = 1'h1;
            p.tx_clk = u[C_TXCLK];
            p.crs = u[C_CRS];
            p.col = u[C_COLOUT];
            // collision obeys both its own and the group enable
            p.col_oe = u[C_COLOE] & u[C_GRPOE];
            p.rx_er = u[C_RXER];
            p.rx_clk = u[C_RXCLK];
            p.rx_dv = u[C_RXDV];
            p.rxd = u[C_RXD0 +: 8];
            p.mac_oe = u[C_GRPOE];
            p.mdio_out = u[C_MDIOOUT];
            p.mdio_oe = u[C_MDIOOE];
            p.irq = u[C_IRQ];
            p.irq_oe = u[C_IRQOE];
            p.led = u[C_LED0 +: 6];
            p.led_oe = u[C_LEDOE];
        end else if (in == I_HIGHZ) begin
            p.clk125_oe = 1'h0;
            p.col_oe = 1'h0;
            p.mac_oe = 1'h0;
            p.mdio_oe = 1'h0;
            p.irq_oe = 1'h0;
            p.led_oe = 1'h0;
        end
        return p;
    endfunction

    // ***************************************************
    // capture vector from synchronised pins and core values
    // ***************************************************
    // chain order
    always_comb begin
        bst_pin_in_t pi;
        bst_pin_out_t co;
        pi = t_ff.pin_s2;
        co = t_ff.core_s2;
        cap_vec = '0;
        cap_vec[C_HWRST] = pi.hw_reset;
        cap_vec[C_CLK125] = co.clk125;
        cap_vec[C_CFG6] = pi.cfg[6];
        cap_vec[C_CFG5] = pi.cfg[5];
        cap_vec[C_COMA] = pi.coma;
        for (int i = 0; i < 8; i++) begin
            cap_vec[C_TXD7 + 7 - i] = pi.txd[i];
        end
        cap_vec[C_TXEN] = pi.tx_en;
        cap_vec[C_GTX] = pi.gtx_clk;
        cap_vec[C_TXER] = pi.tx_er;
        cap_vec[C_TXCLK] = co.tx_clk;
        cap_vec[C_CRS] = co.crs;
        cap_vec[C_COLIN] = pi.col_in;
        cap_vec[C_COLOUT] = co.col;
        cap_vec[C_COLOE] = co.col_oe;
        cap_vec[C_RXER] = co.rx_er;
        cap_vec[C_RXCLK] = co.rx_clk;
        cap_vec[C_RXDV] = co.rx_dv;
        cap_vec[C_RXD0 +: 8] = co.rxd;
        cap_vec[C_GRPOE] = co.mac_oe;
        cap_vec[C_MDC] = pi.mdc;
        cap_vec[C_MDIOIN] = pi.mdio_in;
        cap_vec[C_MDIOOUT] = co.mdio_out;
        cap_vec[C_MDIOOE] = co.mdio_oe;
        cap_vec[C_IRQ] = co.irq;
        cap_vec[C_IRQOE] = co.irq_oe;
        cap_vec[C_LED0 +: 6] = co.led;
        cap_vec[C_LEDOE] = co.led_oe;
        cap_vec[C_CFG0 +: 5] = pi.cfg[4:0];
    end

    // ***************************************************
    // test clock domain, rising edge
    // ***************************************************
    // instruction decode
    assign cur_instr = bst_decode(t_ff.ir);
    assign bsr_sel = (cur_instr == I_EXTEST) || (cur_instr == I_SAMPLE);

    always_comb begin
        nxt_t = t_ff;
        nxt_t.pin_s1 = pin_in;
        nxt_t.pin_s2 = t_ff.pin_s1;
        nxt_t.core_s1 = core_out;
        nxt_t.core_s2 = t_ff.core_s1;
        nxt_t.tap = tap_next(t_ff.tap, tms);
        unique case (t_ff.tap)
            T_RESET: begin
                nxt_t.ir = OP_IDCODE;
                if (t_ff.ir != OP_IDCODE) begin
                    nxt_t.tog = ~t_ff.tog;
                end
            end
            T_CAP_IR: nxt_t.ir_sh = IR_CAPTURE;
            T_SHIFT_IR: nxt_t.ir_sh = {tdi, t_ff.ir_sh[IR_W-1:1]};
            T_UPD_IR: begin
                nxt_t.ir = t_ff.ir_sh;
                nxt_t.tog = ~t_ff.tog;
            end
            T_CAP_DR: begin
                nxt_t.byp = 1'h0;
                nxt_t.id_sh = ID_VALUE;
                if (bsr_sel) begin
                    nxt_t.bsr_sh = cap_vec;
                end
            end
            T_SHIFT_DR: begin
                nxt_t.byp = tdi;
                nxt_t.id_sh = {tdi, t_ff.id_sh[ID_W-1:1]};
                // shift out capture while shifting in
                if (bsr_sel) begin
                    nxt_t.bsr_sh = {tdi, t_ff.bsr_sh[BSR_LEN-1:1]};
                end
            end
            T_UPD_DR: begin
                if (bsr_sel) begin
                    nxt_t.upd = t_ff.bsr_sh;
                    nxt_t.tog = ~t_ff.tog;
                end
            end
            default: ;
        endcase
    end

    always_ff @(posedge tck or negedge test_reset_low) begin
        if (!test_reset_low) begin
            t_ff <= '{tap: T_RESET, ir: OP_IDCODE, default: '0};
        end else begin
            t_ff <= nxt_t;
        end
    end

    // ***************************************************
    // test clock domain, falling edge
    // ***************************************************
    always_comb begin
        nxt_n.tdo_oe = (t_ff.tap == T_SHIFT_IR) || (t_ff.tap == T_SHIFT_DR);
        nxt_n.tdo = 1'h0;
        if (t_ff.tap == T_SHIFT_IR) begin
            nxt_n.tdo = t_ff.ir_sh[0];
        end else if (t_ff.tap == T_SHIFT_DR) begin
            if (bsr_sel) begin
                nxt_n.tdo = t_ff.bsr_sh[0];
            end else if (cur_instr == I_IDCODE) begin
                nxt_n.tdo = t_ff.id_sh[0];
            end else begin
                nxt_n.tdo = t_ff.byp;
            end
        end
    end

    always_ff @(negedge tck or negedge test_reset_low) begin
        if (!test_reset_low) begin
            n_ff <= '0;
        end else begin
            n_ff <= nxt_n;
        end
    end

    // ***************************************************
    // functional clock domain: pin drive
    // ***************************************************
    // instruction and update stage are copied only after the toggle has crossed;
    // both were frozen on the tck edge that flipped it
    always_comb begin
        nxt_c = c_ff;
        nxt_c.tog_s1 = t_ff.tog;
        nxt_c.tog_s2 = c_ff.tog_s1;
        nxt_c.tog_s3 = c_ff.tog_s2;
        nxt_c.trst_s1 = test_reset_low;
        nxt_c.trst_s2 = c_ff.trst_s1;
        if (!c_ff.trst_s2) begin
            nxt_c.instr = I_IDCODE;
        end else if (c_ff.tog_s2 != c_ff.tog_s3) begin
            nxt_c.instr = cur_instr;
            nxt_c.upd = t_ff.upd;
        end
        // core drives except extest, clamp, high-z
        nxt_c.pin_out = drive(c_ff.instr, c_ff.upd, core_out);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            c_ff <= '{instr: I_IDCODE, default: '0};
        end else begin
            c_ff <= nxt_c;
        end
    end

    assign tdo = n_ff.tdo;
    assign tdo_oe = n_ff.tdo_oe;
    assign pin_out = c_ff.pin_out;

endmodule

// ==== bst_tap_properties.sv ====
// checker for the test access port, watching its ports only
// assumes tck rests low between scans and never moves on a clock edge
`timescale 1ns/10ps
module bst_tap_checker (
    // functional side
    input wire logic clock,
    input wire logic rst_n,
    input wire bst_pkg::bst_pin_out_t core_out,
    input wire bst_pkg::bst_pin_out_t pin_out,
    // test port
    input wire logic tck,
    input wire logic tms,
    input wire logic test_reset_low,
    input wire logic tdo,
    input wire logic tdo_oe
);
    import bst_pkg::*;
    logic tck_q_ff;
    logic [3:0] quiet_ff;
    // clocks since the test port last moved; pins settle a few clocks after an update
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tck_q_ff <= 1'h0;
            quiet_ff <= 4'h0;
        end else begin
            tck_q_ff <= tck;
            if (tck != tck_q_ff || !test_reset_low) begin
                quiet_ff <= 4'h0;
            end else if (quiet_ff != 4'hF) begin
                quiet_ff <= quiet_ff + 4'h1;
            end
        end
    end
    // ****
    // properties
    // ****
    sequence s_to_reset;
        tms [*5];
    endsequence
    sequence s_ir_path;
        s_to_reset ##1 !tms ##1 tms ##1 tms ##1 !tms ##1 !tms;
    endsequence
    sequence s_dr_path;
        s_to_reset ##1 !tms ##1 tms ##1 !tms ##1 !tms;
    endsequence
    property p_tdo_idle;
        @(negedge tck) disable iff (!test_reset_low) !tdo_oe |-> !tdo;
    endproperty
    a_tdo_idle: assert property (p_tdo_idle) else $error("tdo high outside shift");
    property p_tdo_fall;
        @(posedge clock) disable iff (!rst_n) $changed(tdo) |-> !tck;
    endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved on rising tck");
    property p_oe_fall;
        @(posedge clock) disable iff (!rst_n) $changed(tdo_oe) |-> !tck;
    endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("tdo_oe moved on rising tck");
    property p_trst_tdo;
        @(posedge clock) disable iff (!rst_n) !test_reset_low |-> !tdo_oe && !tdo;
    endproperty
    a_trst_tdo: assert property (p_trst_tdo) else $error("tdo active in test reset");
    property p_trst_pins;
        @(posedge clock) disable iff (!rst_n) !test_reset_low [*6] |-> pin_out == $past(core_out);
    endproperty
    a_trst_pins: assert property (p_trst_pins) else $error("pins not normal in reset");
    property p_pins_quiet;
        @(posedge clock) disable iff (!rst_n)
            quiet_ff >= 4'h6 && $stable(core_out) |=> $stable(pin_out);
    endproperty
    a_pins_quiet: assert property (p_pins_quiet) else $error("pins moved without update");
    property p_five_tms;
        @(posedge tck) disable iff (!test_reset_low) s_to_reset |=> !tdo_oe;
    endproperty
    a_five_tms: assert property (p_five_tms) else $error("five tms ones did not reset");
    property p_ir_path;
        @(posedge tck) disable iff (!test_reset_low) s_ir_path |=> tdo_oe && tdo;
    endproperty
    a_ir_path: assert property (p_ir_path) else $error("instruction capture wrong");
    property p_dr_path;
        @(posedge tck) disable iff (!test_reset_low) s_dr_path |=> tdo_oe && tdo;
    endproperty
    a_dr_path: assert property (p_dr_path) else $error("id bit 0 not one");
endmodule

bind bst_tap bst_tap_checker u_bst_tap_checker (.clock(clock), .rst_n(rst_n),
    .core_out(core_out), .pin_out(pin_out), .tck(tck), .tms(tms),
    .test_reset_low(test_reset_low), .tdo(tdo), .tdo_oe(tdo_oe));

// ==== bst_tester.sv ====
// scan tester model: makes tck, mode select, data in and test reset
// assumes its tasks are called one at a time; tck rests low between scans
`timescale 1ns/10ps
module bst_tester (
    // test port, tester side
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic test_reset_low,
    input wire logic tdo
);
    import bst_pkg::*;
    logic junk;
    initial begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h0;
        test_reset_low = 1'h0;
    end
    // change while tck low, read tdo just before it rises
    task automatic step(input logic m, input logic d, output logic q);
        #5;
        tms = m;
        tdi = d;
        #35;
        q = tdo;
        tck = 1'h1;
        #40;
        tck = 1'h0;
        // idle data line shows the inverse so a stale value never passes
        tdi = ~d;
    endtask
    task automatic go(input logic m);
        step(m, 1'h0, junk);
    endtask
    // test reset held long enough for the pin logic
    task automatic trst();
        test_reset_low = 1'h0;
        #400;
        test_reset_low = 1'h1;
        go(1'h0);
    endtask
    task automatic tms_reset();
        repeat (5) go(1'h1);
        go(1'h0);
    endtask
    // seven instruction bits, first bit first
    task automatic ir(input logic [6:0] op, output logic [6:0] cap);
        for (int i = 0; i < 4; i++) go(i < 2);
        for (int i = 0; i < 7; i++) step(i == 6, op[i], cap[i]);
        go(1'h1);
        go(1'h0);
    endtask
    // captured bits leave as the new ones enter
    task automatic dr(input int n, input logic [63:0] d, output logic [63:0] q);
        q = '0;
        for (int i = 0; i < 3; i++) go(i == 0);
        for (int i = 0; i < n; i++) step(i == n - 1, d[i], q[i]);
        go(1'h1);
        go(1'h0);
    endtask
endmodule

// ==== bst_tap_bench.sv ====
// self-checking bench for the test access port with a scan tester model
// assumes tester tasks start 3 ns after a clock edge
`timescale 1ns/10ps
module bst_tap_bench;
    import bst_pkg::*;
    // arbitrary identification values
    localparam logic [3:0] VER = 4'h3;
    localparam logic [15:0] PART = 16'h00A5;
    localparam logic [10:0] MAKER = 11'h05A;
    localparam logic [50:0] PAT = 51'h2_96C3_A1E7_2B4D;
    localparam logic [63:0] D = 64'hC3A5_96E1_0F5A_7B2D;
    typedef struct packed {
        logic [6:0] op;
        logic [6:0] len;
        logic [31:0] cap;
    } bst_row_t;
    bst_row_t rows [7] = '{'{OP_SAMPLE, 7'h33, 32'h0}, '{OP_EXTEST, 7'h33, 32'h0},
        '{OP_CLAMP, 7'h01, 32'h0}, '{OP_HIGHZ, 7'h01, 32'h0}, '{OP_BYPASS, 7'h01, 32'h0},
        '{7'h55, 7'h01, 32'h0}, '{OP_IDCODE, 7'h20, {VER, PART, MAKER, 1'h1}}};
    logic clock, rst_n, tck, tms, tdi, test_reset_low, tdo, tdo_oe;
    bst_pin_out_t core_out, pin_out;
    bst_pin_in_t pin_in;
    logic [6:0] cap;
    logic [63:0] q;
    logic [18:0] want;
    int n_errors = 0;
    int n_checks = 0;
    bst_tap #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER)) u_bst_tap (
        .clock(clock), .rst_n(rst_n), .core_out(core_out), .pin_in(pin_in),
        .pin_out(pin_out), .tck(tck), .tms(tms), .tdi(tdi),
        .test_reset_low(test_reset_low), .tdo(tdo), .tdo_oe(tdo_oe));
    bst_tester u_bst_tester (.tck(tck), .tms(tms), .tdi(tdi),
        .test_reset_low(test_reset_low), .tdo(tdo));
    function automatic logic [18:0] pick(input bst_pin_out_t p);
        return {p.crs, p.rxd, p.col_oe, p.mac_oe, p.mdio_out, p.irq_oe, p.led, p.clk125_oe};
    endfunction
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock);
        #3;
    endtask
    initial begin
        clock = 1'h0;
        forever #20 clock = ~clock;
    end
    initial begin
        #1000000;
        n_errors++;
        stop_test();
    end
    initial begin
        rst_n = 1'h0;
        core_out = 29'h15A5_C3E9;
        pin_in = 23'h5B_3C96;
        wait_clk(16);
        rst_n = 1'h1;
        u_bst_tester.trst();
        foreach (rows[r]) begin
            u_bst_tester.ir(rows[r].op, cap);
            chk(cap, IR_CAPTURE);
            u_bst_tester.dr(64, D, q);
            chk(q >> rows[r].len, D & ~(~64'h0 << (7'h40 - rows[r].len)));
            if (rows[r].len < 7'h33) chk(q & ~(~64'h0 << rows[r].len), rows[r].cap);
        end
        // ****
        // preload, extest, clamp, high-z, resets
        // ****
        u_bst_tester.ir(OP_SAMPLE, cap);
        u_bst_tester.dr(51, 64'(PAT), q);
        chk({q[C_HWRST], q[C_TXD7], q[C_CRS]}, {pin_in.hw_reset, pin_in.txd[7], core_out.crs});
        chk({q[C_MDIOIN], q[C_MDIOOUT]}, {pin_in.mdio_in, core_out.mdio_out});
        chk({q[C_MDIOOE], q[C_COLOE], q[C_GRPOE]}, {core_out.mdio_oe, core_out.col_oe, core_out.mac_oe});
        wait_clk(6);
        chk(pin_out, core_out);
        u_bst_tester.ir(OP_EXTEST, cap);
        wait_clk(6);
        want = {PAT[C_CRS], PAT[C_RXD0+7:C_RXD0], PAT[C_COLOE] & PAT[C_GRPOE], PAT[C_GRPOE],
            PAT[C_MDIOOUT], PAT[C_IRQOE], PAT[C_LED0+5:C_LED0], 1'h1};
        chk(pick(pin_out), want);
        chk({pin_out.mdio_oe, pin_out.led_oe}, {PAT[C_MDIOOE], PAT[C_LEDOE]});
        chk({pin_out.col, pin_out.irq, pin_out.rx_dv}, {PAT[C_COLOUT], PAT[C_IRQ], PAT[C_RXDV]});
        u_bst_tester.ir(OP_CLAMP, cap);
        core_out = ~core_out;
        wait_clk(6);
        chk(pick(pin_out), want);
        // a data scan under clamp goes through bypass and must not reach the update stage
        u_bst_tester.dr(51, 64'h0, q);
        wait_clk(6);
        chk(pick(pin_out), want);
        u_bst_tester.ir(OP_HIGHZ, cap);
        wait_clk(6);
        chk({pin_out.col_oe, pin_out.mac_oe, pin_out.mdio_oe, pin_out.irq_oe}, 4'h0);
        chk({pin_out.clk125_oe, pin_out.led_oe, pin_out.crs}, {2'h0, core_out.crs});
        u_bst_tester.trst();
        wait_clk(6);
        chk(pin_out, core_out);
        u_bst_tester.dr(32, 64'h0, q);
        chk(q, {VER, PART, MAKER, 1'h1});
        u_bst_tester.tms_reset();
        u_bst_tester.ir(OP_BYPASS, cap);
        u_bst_tester.tms_reset();
        u_bst_tester.dr(32, 64'h0, q);
        chk(q, {VER, PART, MAKER, 1'h1});
        stop_test();
    end
endmodule
